//--- rtl/mii_link_params.svh
// Constants of the MII framing port
`ifndef MII_LINK_PARAMS_SVH
`define MII_LINK_PARAMS_SVH
// Notes on behaviour
// [RQ1] Frame starts on valid; J, K replace data
// [RQ2] Partner raises valid a cycle after accept
// [RQ3] Idle per waiting accept cycle after first
// [RQ4] Valid drop after accept cycle ends frame
// [RQ5] Accept may drop mid-frame for backpressure
// [RQ6] Partner drops valid after accept drops
// [RQ7] Partner resumes valid right after accept returns
// [RQ8] Missing valid after accept return inserts Idle
// [RQ9] Receive start shown as K nibble
// [RQ10] Received J nibble never reaches outputs
// [RQ11] One shared clock; reset clears framing state
`define NIB_J        4'h3
`define NIB_K        4'h4
`define NIB_T        4'hd
`define NIB_R        4'h7
`define NIB_IDLE     4'h0
`define START_CYCLES 2'h2
`endif

//--- rtl/mii_link_pkg.sv
// Types of the MII framing port
`default_nettype none
package mii_link_pkg;
   typedef enum logic [1:0] {SYM_DATA, SYM_IDLE, SYM_START, SYM_END} sym_kind_e;
endpackage : mii_link_pkg
`default_nettype wire

//--- rtl/mii_rx_strip.sv
// Receive side: drops the J nibble, shows K as frame start
`timescale 1ns/100ps
`default_nettype none
`include "mii_link_params.svh"
module mii_rx_strip
   import mii_link_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       link_valid_i,
   input  wire logic [3:0] link_nibble_i,
   output logic            rx_dv_o,
   output logic [3:0]      rx_data_o
);
   logic       dv_reg, dv_next;
   logic [3:0] data_reg, data_next;
   logic       in_frame_reg, in_frame_next;

   always_comb begin
      dv_next       = 1'b0;
      data_next     = data_reg;
      in_frame_next = in_frame_reg;
      if (!link_valid_i) begin
         in_frame_next = 1'b0;
      end else if (!in_frame_reg) begin
         if (link_nibble_i == `NIB_K) begin // [RQ9]
            in_frame_next = 1'b1;
            dv_next       = 1'b1;
            data_next     = `NIB_K;
         end
         // J and idle before K are swallowed [RQ10]
      end else begin
         dv_next   = 1'b1;
         data_next = link_nibble_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin // [RQ11]
         dv_reg       <= 1'b0;
         data_reg     <= 4'h0;
         in_frame_reg <= 1'b0;
      end else begin
         dv_reg       <= dv_next;
         data_reg     <= data_next;
         in_frame_reg <= in_frame_next;
      end
   end

   assign rx_dv_o   = dv_reg;
   assign rx_data_o = data_reg;

   no_j_out_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ10]
      ($rose(rx_dv_o) |-> rx_data_o == `NIB_K))
      else $error("frame start on receive is not K");
endmodule : mii_rx_strip
`default_nettype wire

//--- rtl/mii_link_port.sv
// MII framing port: transmit framer and receive stripper
`timescale 1ns/100ps
`default_nettype none
`include "mii_link_params.svh"
module mii_link_port
   import mii_link_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       tx_en_i,
   input  wire logic [3:0] tx_data_i,
   output logic            tx_accept_o,
   input  wire logic       link_hold_i,
   output logic            link_tx_valid_o,
   output logic [3:0]      link_tx_nibble_o,
   input  wire logic       link_rx_valid_i,
   input  wire logic [3:0] link_rx_nibble_i,
   output logic            rx_dv_o,
   output logic [3:0]      rx_data_o
);
   // ***************************************
   // Transmit framer
   // ***************************************
   typedef enum logic [2:0] {TX_WAIT, TX_START, TX_DATA, TX_TERM, TX_REND} tx_state_e;

   tx_state_e  state_reg, state_next;
   logic [1:0] start_cnt_reg, start_cnt_next;
   logic       acc_d_reg, acc_d_next;
   logic       acc_dd_reg, acc_dd_next;
   logic       en_d_reg, en_d_next;
   logic       out_v_reg, out_v_next;
   logic [3:0] out_n_reg, out_n_next;
   sym_kind_e  kind_reg, kind_next;
   logic       accept;

   // Backpressure from link side, also during J and K; accept always low during T and R
   assign accept      = !link_hold_i && (state_reg == TX_WAIT || state_reg == TX_DATA
                                         || state_reg == TX_START); // [RQ5]
   assign tx_accept_o = accept;

   always_comb begin
      state_next     = state_reg;
      start_cnt_next = start_cnt_reg;
      acc_d_next     = accept;
      acc_dd_next    = acc_d_reg;
      en_d_next      = tx_en_i;
      out_v_next     = 1'b0;
      out_n_next     = out_n_reg;
      kind_next      = kind_reg;
      unique case (state_reg)
         TX_WAIT: begin
            if (tx_en_i && accept) begin // [RQ1]
               state_next     = TX_START;
               start_cnt_next = 2'h1;
               out_v_next     = 1'b1;
               out_n_next     = `NIB_J;
               kind_next      = SYM_START;
            end else if (accept && acc_d_reg) begin // [RQ3]
               out_v_next = 1'b1;
               out_n_next = `NIB_IDLE;
               kind_next  = SYM_IDLE;
            end
         end
         TX_START: begin
            // Data ignored while K goes out [RQ1]
            out_v_next     = 1'b1;
            out_n_next     = `NIB_K;
            kind_next      = SYM_START;
            start_cnt_next = start_cnt_reg + 2'h1;
            if (start_cnt_next == `START_CYCLES) begin
               state_next = TX_DATA;
            end
         end
         TX_DATA: begin
            if (tx_en_i) begin
               out_v_next = 1'b1;
               out_n_next = tx_data_i;
               kind_next  = SYM_DATA;
            end else if (acc_d_reg && en_d_reg) begin // [RQ4]
               state_next = TX_TERM;
               out_v_next = 1'b1;
               out_n_next = `NIB_T;
               kind_next  = SYM_END;
            end else if (acc_d_reg && !acc_dd_reg) begin // [RQ8]
               // Accept came back a cycle ago and valid is still low;
               // the partner missed its resume slot, so one Idle fills it
               out_v_next = 1'b1;
               out_n_next = `NIB_IDLE;
               kind_next  = SYM_IDLE;
            end
            // Valid low while held off is legal [RQ6] [RQ7]
         end
         TX_TERM: begin
            state_next = TX_REND;
            out_v_next = 1'b1;
            out_n_next = `NIB_R;
            kind_next  = SYM_END;
         end
         TX_REND: begin
            state_next = TX_WAIT;
         end
         default: begin
            state_next = TX_WAIT;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin // [RQ11]
         state_reg     <= TX_WAIT;
         start_cnt_reg <= 2'h0;
         acc_d_reg     <= 1'b0;
         acc_dd_reg    <= 1'b0;
         en_d_reg      <= 1'b0;
         out_v_reg     <= 1'b0;
         out_n_reg     <= 4'h0;
         kind_reg      <= SYM_IDLE;
      end else begin
         state_reg     <= state_next;
         start_cnt_reg <= start_cnt_next;
         acc_d_reg     <= acc_d_next;
         acc_dd_reg    <= acc_dd_next;
         en_d_reg      <= en_d_next;
         out_v_reg     <= out_v_next;
         out_n_reg     <= out_n_next;
         kind_reg      <= kind_next;
      end
   end

   assign link_tx_valid_o  = out_v_reg;
   assign link_tx_nibble_o = out_n_reg;

   // ***************************************
   // Receive side
   // ***************************************
   mii_rx_strip u_rx_strip (
      .core_clk_i    (core_clk_i),
      .reset_n_i     (reset_n_i),
      .link_valid_i  (link_rx_valid_i),
      .link_nibble_i (link_rx_nibble_i),
      .rx_dv_o       (rx_dv_o),
      .rx_data_o     (rx_data_o)
   );

   // ***************************************
   // Checks
   // ***************************************
   start_j_k_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ1]
      (state_reg == TX_WAIT && tx_en_i && accept)
      |=> (link_tx_nibble_o == `NIB_J && link_tx_valid_o)
          ##1 (link_tx_nibble_o == `NIB_K && link_tx_valid_o))
      else $error("start delimiter not J then K");

   wait_idle_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ3]
      (state_reg == TX_WAIT && !tx_en_i && accept && acc_d_reg)
      |=> (link_tx_valid_o && link_tx_nibble_o == `NIB_IDLE))
      else $error("no idle while waiting for valid");

   end_t_r_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ4]
      (state_reg == TX_DATA && !tx_en_i && acc_d_reg && en_d_reg)
      |=> (link_tx_nibble_o == `NIB_T) ##1 (link_tx_nibble_o == `NIB_R))
      else $error("end delimiter not T then R");

   hold_accept_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ5]
      (link_hold_i |-> !tx_accept_o))
      else $error("accept high while held off");

   resume_idle_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ8]
      (state_reg == TX_DATA && acc_d_reg && !acc_dd_reg && !tx_en_i && !en_d_reg)
      |=> (link_tx_valid_o && link_tx_nibble_o == `NIB_IDLE))
      else $error("no idle after missed resume");

   data_pass_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ1]
      (state_reg == TX_DATA && tx_en_i)
      |=> (link_tx_valid_o && link_tx_nibble_o == $past(tx_data_i)))
      else $error("data nibble not forwarded");

   // ***************************************
   // Symbol kind, delimiter and hold-off checks
   // ***************************************
   // Kind travels beside the nibble, so a data nibble equal to a code is no alarm
   kind_idle_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ3]
      ((link_tx_valid_o && kind_reg == SYM_IDLE) |-> link_tx_nibble_o == `NIB_IDLE))
      else $error("idle symbol carries wrong code");

   kind_start_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ1]
      ((link_tx_valid_o && kind_reg == SYM_START)
       |-> (link_tx_nibble_o == `NIB_J || link_tx_nibble_o == `NIB_K)))
      else $error("start symbol is neither J nor K");

   kind_end_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ4]
      ((link_tx_valid_o && kind_reg == SYM_END)
       |-> (link_tx_nibble_o == `NIB_T || link_tx_nibble_o == `NIB_R)))
      else $error("end symbol is neither T nor R");

   start_k_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ1]
      (state_reg == TX_START |=> (link_tx_valid_o && link_tx_nibble_o == `NIB_K)))
      else $error("second start cycle is not K");

   start_len_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ1]
      (state_reg == TX_START |=> state_reg == TX_DATA))
      else $error("start delimiter longer than two cycles");

   data_kind_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ8]
      ((state_reg == TX_DATA && tx_en_i) |=> (link_tx_valid_o && kind_reg == SYM_DATA)))
      else $error("idle put in place of a resumed nibble");

   held_quiet_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ5]
      ((state_reg == TX_DATA && !tx_en_i && !accept && !acc_d_reg) |=> !link_tx_valid_o))
      else $error("symbol written while held off");

   delim_no_acc_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ5]
      ((state_reg == TX_TERM || state_reg == TX_REND) |-> !tx_accept_o))
      else $error("accept high during end delimiter");

   rend_quiet_a : assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [RQ4]
      (state_reg == TX_REND |=> !link_tx_valid_o))
      else $error("symbol written in the gap after R");
endmodule : mii_link_port
`default_nettype wire

//--- tb/mac_model.sv
// Nibble-wide Ethernet source that follows the accept handshake
`timescale 1ns/100ps
`default_nettype none
module mac_model (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       accept_i,
   input  wire logic [1:0] lag_i,
   output logic            en_o,
   output logic [3:0]      data_o
);
   // ************
   // Source state
   // ************
   logic [3:0]  q[$];
   int          idx  = 0;
   logic [1:0]  pre  = 2'h0;
   logic [1:0]  wcnt = 2'h0;
   logic [31:0] junk = 32'h1;
   // Start cycles carry junk on purpose, since the port must ignore them
   assign data_o = (pre < 2'h2) ? junk[3:0] : q[idx];
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_o <= 1'b0;
         pre  <= 2'h0;
         wcnt <= 2'h0;
      end else if (en_o) begin
         junk <= {junk[30:0], junk[31] ^ junk[21] ^ junk[1] ^ junk[0]};
         if (pre < 2'h2) pre <= pre + 2'h1;
         else idx <= idx + 1;
         if (pre == 2'h2 && idx == q.size() - 1 && accept_i) begin
            en_o <= 1'b0;
            pre  <= 2'h0;
         end else if (!accept_i) en_o <= 1'b0;
      end else if (idx < q.size() && accept_i) begin
         // A nonzero lag breaks the resume timing to force an Idle
         if (wcnt >= lag_i) begin
            en_o <= 1'b1;
            wcnt <= 2'h0;
         end else wcnt <= wcnt + 2'h1;
      end
   end
endmodule : mac_model
`default_nettype wire

//--- tb/mii_link_port_bench.sv
// Bench of the MII framing port
`timescale 1ns/100ps
`default_nettype none
`include "mii_link_params.svh"
module mii_link_port_bench;
   logic       clk = 1'b0, rst_n = 1'b0, hold = 1'b0, rxv = 1'b0;
   logic [3:0] rxd = 4'h0, td, tn, rd;
   logic [1:0] lag = 2'h0;
   logic       en, acc, tv, dv;
   logic [3:0] txg[$], txe[$], rxg[$], rxe[$];
   int         n_fail = 0, tests_run = 0;
   int         n_idle = 0;
   logic [31:0] r = 32'hb42a;
   mii_link_port dut (.core_clk_i(clk), .reset_n_i(rst_n), .tx_en_i(en), .tx_data_i(td),
      .tx_accept_o(acc), .link_hold_i(hold), .link_tx_valid_o(tv), .link_tx_nibble_o(tn),
      .link_rx_valid_i(rxv), .link_rx_nibble_i(rxd), .rx_dv_o(dv), .rx_data_o(rd));
   mac_model mac (.clk_i(clk), .rst_n_i(rst_n), .accept_i(acc), .lag_i(lag), .en_o(en),
      .data_o(td));
   // ********
   // Checking
   // ********
   initial forever #20 clk = ~clk;
   // Idle fills are dropped, so data nibbles are never drawn as zero
   always @(posedge clk) begin
      if (tv && tn !== `NIB_IDLE) txg.push_back(tn);
      // Idles between K and T, the only ones that land inside a packet
      if (tv && tn === `NIB_IDLE && txg.size() >= 2 && txg.size() + 2 < txe.size()) n_idle++;
      if (dv) rxg.push_back(rd);
   end
   function automatic logic [3:0] nib();
      r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
      return (r[3:0] == `NIB_IDLE) ? 4'h1 : r[3:0];
   endfunction : nib
   task check(input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check
   task stop_test();
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   task tx_frame(input int n, input logic [1:0] lg, input bit bp);
      logic [3:0] d;
      @(posedge clk);
      lag <= lg;
      @(negedge clk);
      n_idle = 0;
      txe = {`NIB_J, `NIB_K};
      for (int i = 0; i < n; i++) begin
         d = nib();
         mac.q.push_back(d);
         txe.push_back(d);
      end
      txe.push_back(`NIB_T);
      txe.push_back(`NIB_R);
      if (bp) begin
         while (!(en && mac.pre == 2'h2)) @(posedge clk);
         @(posedge clk) hold <= 1'b1;
         repeat (3) @(posedge clk);
         hold <= 1'b0;
      end
      while (mac.idx != mac.q.size() || en) @(posedge clk);
      repeat (6) @(posedge clk);
      check(8'(txg.size()), 8'(txe.size()));
      foreach (txe[i]) check({4'h0, txg[i]}, {4'h0, txe[i]});
      check(8'(n_idle), (bp && lg != 2'h0) ? 8'h1 : 8'h0);
      txg.delete();
      $display("tx frame n=%0d lag=%0d hold=%0d done", n, lg, bp);
   endtask : tx_frame
   task rx_frame(input int n);
      logic [3:0] s[$];
      s = {nib(), nib(), `NIB_J, `NIB_K};
      if (s[0] == `NIB_K) s[0] = 4'h1;
      if (s[1] == `NIB_K) s[1] = 4'h1;
      rxe = {`NIB_K};
      for (int i = 0; i < n; i++) begin
         s.push_back(nib());
         rxe.push_back(s[$]);
      end
      foreach (s[i]) begin
         @(posedge clk);
         rxv <= 1'b1;
         rxd <= s[i];
      end
      @(posedge clk) rxv <= 1'b0;
      repeat (3) @(posedge clk);
      check(8'(rxg.size()), 8'(rxe.size()));
      foreach (rxe[i]) check({4'h0, rxg[i]}, {4'h0, rxe[i]});
      rxg.delete();
      $display("rx frame n=%0d done", n);
   endtask : rx_frame
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      tx_frame(4, 2'h0, 1'b0);
      tx_frame(1, 2'h2, 1'b0);
      tx_frame(8, 2'h0, 1'b1);
      tx_frame(7, 2'h1, 1'b1);
      for (int i = 0; i < 8; i++) begin
         void'(nib());
         tx_frame(6 + int'(r[2:0]), r[4:3], r[5]);
         rx_frame(1 + int'(r[8:6]));
      end
      rx_frame(0);
      stop_test();
   end
endmodule : mii_link_port_bench
`default_nettype wire
